//--- hdl/ctrl_regs_pkg.sv
package ctrl_regs_pkg;
    localparam int          ADDR_W   = 7;
    localparam int          DATA_W   = 8;
    localparam logic [6:0]  SEL_ADDR = 7'h1D;
    localparam logic [6:0]  PWR_ADDR = 7'h1E;
    localparam logic [7:0]  SEL_RST  = 8'h80;
    localparam logic [7:0]  PWR_RST  = 8'h07;
    // selector fields
    localparam int          SRC_LSB  = 0;
    localparam int          SRC_MSB  = 2;
    localparam int          REP_BIT  = 3;
    localparam int          FLG_BIT  = 4;
    localparam int          GPO_BIT  = 5;
    localparam int          TRB_BIT  = 6;
    localparam int          HRT_BIT  = 7;
    // power fields
    localparam int          SYN_BIT  = 0;
    localparam int          RXP_BIT  = 1;
    localparam int          TXP_BIT  = 2;
    localparam int          OSC_BIT  = 3;
    localparam int          AIF_BIT  = 4;
    localparam int          HIZ_BIT  = 5;
    localparam int          PWR_USED = 6;
    // read-back source codes
    localparam logic [2:0]  SRC_INT  = 3'h0;
    localparam logic [2:0]  SRC_CS5  = 3'h5;
    localparam logic [2:0]  SRC_RXS  = 3'h6;
    localparam int          NUM_CS   = 5;
    localparam int          RATE_HI_KHZ = 192;
    localparam int          RATE_LO_KHZ = 96;
endpackage

//--- hdl/readback_mux.sv
`timescale 1ns/100ps
module readback_mux (
    input  wire logic [2:0]                         sel,
    input  wire logic [7:0]                         int_status,
    input  wire logic [ctrl_regs_pkg::NUM_CS*8-1:0] chan_status,
    input  wire logic [7:0]                         rx_status,
    output logic      [7:0]                         data
);
    import ctrl_regs_pkg::*;

    always_comb begin
        data = 8'h00;
        if (sel == SRC_INT) begin
            data = int_status;
        end else if (sel == SRC_RXS) begin
            data = rx_status;
        end else if (sel <= SRC_CS5) begin
            data = chan_status[(32'(sel) - 1) * 8 +: 8];
        end
    end
endmodule

//--- hdl/status_select_power_control.sv
`timescale 1ns/100ps
//
// Behaviour
// RL1: bits 2:0 pick read-back: interrupt, channel status 1-5, receiver.
// RL2: bit 3 enables continuous read-back; resets off.
// RL3: bit 4 enables flags-appended mode; resets off.
// RL4: bit 5 makes upper receive pins general outputs; resets as inputs.
// RL5: bit 6 at zero truncates received words; at one passes them whole.
// RL6: bit 7 at one allows 192kHz receive, at zero caps at 96kHz.
// RL7: power bit 0 disables the synthesiser; resets to one.
// RL8: power bit 1 disables the receiver; resets to one.
// RL9: power bit 2 disables the transmitter; resets to one.
// RL10: power bit 3 stops the crystal oscillator; resets to zero.
// RL11: power bit 4 powers down the audio port; resets to zero.
// RL12: power bit 5 tri-states every output; resets to zero.
module status_select_power_control (
    input  wire logic                               clock,
    input  wire logic                               rst_n,
    input  wire logic                               clk_en,
    input  wire logic                               wr_en,
    input  wire logic [ctrl_regs_pkg::ADDR_W-1:0]   addr,
    input  wire logic [ctrl_regs_pkg::DATA_W-1:0]   wr_data,
    input  wire logic [ctrl_regs_pkg::DATA_W-1:0]   int_status,
    input  wire logic [ctrl_regs_pkg::NUM_CS*8-1:0] chan_status,
    input  wire logic [ctrl_regs_pkg::DATA_W-1:0]   rx_status,
    output logic      [ctrl_regs_pkg::DATA_W-1:0]   status_rd_data,
    output logic      [ctrl_regs_pkg::DATA_W-1:0]   sel_rd_data,
    output logic      [ctrl_regs_pkg::DATA_W-1:0]   pwr_rd_data,
    output logic      [2:0]                         readback_source_select,
    output logic                                    repeat_readback_enable,
    output logic                                    flags_appended_mode,
    output logic                                    upper_inputs_as_outputs,
    output logic                                    word_truncation_bypass,
    output logic                                    high_rate_receive_enable,
    output logic      [7:0]                         max_rate_khz,
    output logic                                    synth_power_off,
    output logic                                    receiver_power_off,
    output logic                                    transmitter_power_off,
    output logic                                    crystal_osc_power_off,
    output logic                                    audio_port_power_off,
    output logic                                    outputs_high_impedance
);
    import ctrl_regs_pkg::*;

    logic [DATA_W-1:0] sel_q;
    logic [DATA_W-1:0] pwr_q;
    logic [DATA_W-1:0] mux_data;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sel_q <= SEL_RST; // [RL2] [RL3] [RL4] [RL5] [RL6]
        end else if (clk_en && wr_en && addr == SEL_ADDR) begin
            sel_q <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pwr_q <= PWR_RST; // [RL7] [RL8] [RL9] [RL10] [RL11] [RL12]
        end else if (clk_en && wr_en && addr == PWR_ADDR) begin
            pwr_q <= {2'b00, wr_data[PWR_USED-1:0]};
        end
    end

    // ----------------------------------------
    // control outputs
    // ----------------------------------------
    assign readback_source_select   = sel_q[SRC_MSB:SRC_LSB];
    assign repeat_readback_enable   = sel_q[REP_BIT];   // [RL2]
    assign flags_appended_mode      = sel_q[FLG_BIT];   // [RL3]
    assign upper_inputs_as_outputs  = sel_q[GPO_BIT];   // [RL4]
    assign word_truncation_bypass   = sel_q[TRB_BIT];   // [RL5]
    assign high_rate_receive_enable = sel_q[HRT_BIT];   // [RL6]
    assign max_rate_khz = sel_q[HRT_BIT] ? 8'(RATE_HI_KHZ)
                                         : 8'(RATE_LO_KHZ); // [RL6]
    assign synth_power_off          = pwr_q[SYN_BIT];   // [RL7]
    assign receiver_power_off       = pwr_q[RXP_BIT];   // [RL8]
    assign transmitter_power_off    = pwr_q[TXP_BIT];   // [RL9]
    assign crystal_osc_power_off    = pwr_q[OSC_BIT];   // [RL10]
    assign audio_port_power_off     = pwr_q[AIF_BIT];   // [RL11]
    assign outputs_high_impedance   = pwr_q[HIZ_BIT];   // [RL12]
    assign sel_rd_data              = sel_q;
    assign pwr_rd_data              = pwr_q;

    // ----------------------------------------
    // status read-back
    // ----------------------------------------
    readback_mux u_mux (
        .sel         (sel_q[SRC_MSB:SRC_LSB]),
        .int_status  (int_status),
        .chan_status (chan_status),
        .rx_status   (rx_status),
        .data        (mux_data)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status_rd_data <= 8'h00;
        end else if (clk_en) begin
            status_rd_data <= mux_data; // [RL1]
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_src_int;
        @(posedge clock) disable iff (!rst_n)
        clk_en && sel_q[SRC_MSB:SRC_LSB] == SRC_INT
            |=> status_rd_data == $past(int_status);
    endproperty
    a_src_int: assert property (p_src_int) // [RL1]
        else $error("interrupt status not returned");

    property p_src_rx;
        @(posedge clock) disable iff (!rst_n)
        clk_en && sel_q[SRC_MSB:SRC_LSB] == SRC_RXS
            |=> status_rd_data == $past(rx_status);
    endproperty
    a_src_rx: assert property (p_src_rx) // [RL1]
        else $error("receiver status not returned");

    property p_sel_wr;
        @(posedge clock) disable iff (!rst_n)
        clk_en && wr_en && addr == SEL_ADDR
            |=> flags_appended_mode == $past(wr_data[FLG_BIT])
                && repeat_readback_enable == $past(wr_data[REP_BIT]);
    endproperty
    a_sel_wr: assert property (p_sel_wr) // [RL3]
        else $error("selector write not applied");

    property p_sel_rst;
        @(posedge clock)
        !rst_n |=> high_rate_receive_enable && !upper_inputs_as_outputs
                   && !word_truncation_bypass && !repeat_readback_enable;
    endproperty
    a_sel_rst: assert property (p_sel_rst) // [RL6]
        else $error("selector reset value wrong");

    property p_rate;
        @(posedge clock) disable iff (!rst_n)
        max_rate_khz == (high_rate_receive_enable ? 8'(RATE_HI_KHZ)
                                                  : 8'(RATE_LO_KHZ));
    endproperty
    a_rate: assert property (p_rate) // [RL6]
        else $error("rate cap mismatch");

    property p_pwr_rst;
        @(posedge clock)
        !rst_n |=> synth_power_off && receiver_power_off
                   && transmitter_power_off && !crystal_osc_power_off
                   && !audio_port_power_off && !outputs_high_impedance;
    endproperty
    a_pwr_rst: assert property (p_pwr_rst) // [RL8]
        else $error("power reset value wrong");

    property p_pwr_wr;
        @(posedge clock) disable iff (!rst_n)
        clk_en && wr_en && addr == PWR_ADDR
            |=> outputs_high_impedance == $past(wr_data[HIZ_BIT])
                && synth_power_off == $past(wr_data[SYN_BIT]);
    endproperty
    a_pwr_wr: assert property (p_pwr_wr) // [RL12]
        else $error("power write not applied");

    property p_freeze;
        @(posedge clock) disable iff (!rst_n)
        !clk_en |=> $stable(sel_q) && $stable(pwr_q);
    endproperty
    a_freeze: assert property (p_freeze) // [RL9]
        else $error("state changed while frozen");

    property p_src_cs1;
        @(posedge clock) disable iff (!rst_n)
        clk_en && sel_q[SRC_MSB:SRC_LSB] == 3'(SRC_INT + 3'h1)
            |=> status_rd_data == $past(chan_status[DATA_W-1:0]);
    endproperty
    a_src_cs1: assert property (p_src_cs1) // [RL1]
        else $error("channel status one not returned");

    property p_src_cs5;
        @(posedge clock) disable iff (!rst_n)
        clk_en && sel_q[SRC_MSB:SRC_LSB] == SRC_CS5
            |=> status_rd_data
                == $past(chan_status[NUM_CS*DATA_W-1 -: DATA_W]);
    endproperty
    a_src_cs5: assert property (p_src_cs5) // [RL1]
        else $error("channel status five not returned");

    property p_src_none;
        @(posedge clock) disable iff (!rst_n)
        clk_en && sel_q[SRC_MSB:SRC_LSB] > SRC_RXS
            |=> status_rd_data == '0;
    endproperty
    a_src_none: assert property (p_src_none) // [RL1]
        else $error("unused source code not zero");

    property p_stat_freeze;
        @(posedge clock) disable iff (!rst_n)
        !clk_en |=> $stable(status_rd_data);
    endproperty
    a_stat_freeze: assert property (p_stat_freeze) // [RL1]
        else $error("read-back changed while frozen");

    property p_sel_wr_hi;
        @(posedge clock) disable iff (!rst_n)
        clk_en && wr_en && addr == SEL_ADDR
            |=> readback_source_select == $past(wr_data[SRC_MSB:SRC_LSB])
                && upper_inputs_as_outputs == $past(wr_data[GPO_BIT])
                && word_truncation_bypass == $past(wr_data[TRB_BIT])
                && high_rate_receive_enable == $past(wr_data[HRT_BIT]);
    endproperty
    a_sel_wr_hi: assert property (p_sel_wr_hi) // [RL4]
        else $error("selector upper fields not applied");

    property p_pwr_wr_mid;
        @(posedge clock) disable iff (!rst_n)
        clk_en && wr_en && addr == PWR_ADDR
            |=> receiver_power_off == $past(wr_data[RXP_BIT])
                && transmitter_power_off == $past(wr_data[TXP_BIT])
                && crystal_osc_power_off == $past(wr_data[OSC_BIT])
                && audio_port_power_off == $past(wr_data[AIF_BIT]);
    endproperty
    a_pwr_wr_mid: assert property (p_pwr_wr_mid) // [RL10]
        else $error("power middle fields not applied");
endmodule

//--- dv/test_status_select_power_control.sv
`timescale 1ns/100ps
module test_status_select_power_control;
    import ctrl_regs_pkg::*;
    logic              clock, rst_n, clk_en, wr_en;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wr_data, int_status, rx_status;
    logic [39:0]       chan_status;
    logic [7:0]        status_rd_data, sel_rd_data, pwr_rd_data, max_rate_khz;
    logic [2:0]        src;
    logic              rep, flg, general_output_pin, trb, hrt, syn, rxp, txp, osc, aif, hiz;
    int                failures, n_tests;

    status_select_power_control u_status_select_power_control (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .wr_en(wr_en),
        .addr(addr), .wr_data(wr_data), .int_status(int_status),
        .chan_status(chan_status), .rx_status(rx_status),
        .status_rd_data(status_rd_data), .sel_rd_data(sel_rd_data),
        .pwr_rd_data(pwr_rd_data), .readback_source_select(src),
        .repeat_readback_enable(rep), .flags_appended_mode(flg),
        .upper_inputs_as_outputs(general_output_pin), .word_truncation_bypass(trb),
        .high_rate_receive_enable(hrt), .max_rate_khz(max_rate_khz),
        .synth_power_off(syn), .receiver_power_off(rxp),
        .transmitter_power_off(txp), .crystal_osc_power_off(osc),
        .audio_port_power_off(aif), .outputs_high_impedance(hiz));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic chk(input string      n,
                       input logic [7:0] s,
                       input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic test_done;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic chk_sel(input logic [7:0] d);
        chk("sel_reg", sel_rd_data, d);
        chk("sel_lo", {3'h0, flg, rep, src}, {3'h0, d[4:0]});
        chk("sel_gpo", {7'h0, general_output_pin}, {7'h0, d[5]});
        chk("sel_hi", {6'h0, hrt, trb}, {6'h0, d[7:6]});
        chk("max_rate", max_rate_khz, d[7] ? 8'hC0 : 8'h60);
    endtask

    task automatic chk_pwr(input logic [7:0] d);
        chk("pwr_reg", pwr_rd_data, {2'h0, d[5:0]});
        chk("pwr_b10", {6'h0, rxp, syn}, {6'h0, d[1:0]});
        chk("pwr_b32", {6'h0, osc, txp}, {6'h0, d[3:2]});
        chk("pwr_b54", {6'h0, hiz, aif}, {6'h0, d[5:4]});
    endtask

    // expected read-back for each source code
    function automatic logic [7:0] exp_src(input int c);
        case (c)
            0:       return 8'hA5;
            6:       return 8'h9C;
            7:       return 8'h00;
            default: return 8'(8'h11 * c);
        endcase
    endfunction

    initial begin
        repeat (2000) @(posedge clock);
        failures++;
        test_done;
    end

    initial begin
        rst_n = 1'b0; clk_en = 1'b1; wr_en = 1'b0; addr = 7'h00;
        wr_data = 8'h00; int_status = 8'hA5; rx_status = 8'h9C;
        chan_status = {8'h55, 8'h44, 8'h33, 8'h22, 8'h11};
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk_sel(SEL_RST);
        chk_pwr(PWR_RST);
        chk("status_rst", status_rd_data, 8'h00);
        // every read-back source code, 7 reads zero
        for (int c = 0; c < 8; c++) begin
            wr(SEL_ADDR, 8'(c));
            chk_sel(8'(c));
            @(posedge clock);
            #1;
            chk("status", status_rd_data, exp_src(c));
        end
        for (int i = 3; i < 8; i++) begin
            wr(SEL_ADDR, 8'h01 << i);
            chk_sel(8'h01 << i);
        end
        for (int i = 0; i < 6; i++) begin
            wr(PWR_ADDR, 8'h01 << i);
            chk_pwr(8'h01 << i);
        end
        wr(PWR_ADDR, 8'hFF);
        chk_pwr(8'hFF);
        // unmapped addresses leave both registers alone
        wr(7'h1F, 8'h00);
        wr(7'h1C, 8'h00);
        chk_pwr(8'hFF);
        chk_sel(8'h80);
        // frozen while clock enable is low, read-back held too
        @(posedge clock);
        clk_en     <= 1'b0;
        int_status <= 8'h3C;
        wr(PWR_ADDR, 8'h00);
        chk_pwr(8'hFF);
        chk("status_frozen", status_rd_data, 8'hA5);
        @(posedge clock);
        clk_en <= 1'b1;
        @(posedge clock);
        #1;
        chk("status_thawed", status_rd_data, 8'h3C);
        // back-to-back writes to both registers
        @(posedge clock);
        wr_en <= 1'b1; addr <= SEL_ADDR; wr_data <= 8'h43;
        @(posedge clock);
        addr <= PWR_ADDR; wr_data <= 8'h12;
        @(posedge clock);
        wr_en <= 1'b0;
        #1;
        chk_sel(8'h43);
        chk_pwr(8'h12);
        // second reset in mid-run
        @(posedge clock);
        rst_n <= 1'b0;
        @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk_sel(SEL_RST);
        chk_pwr(PWR_RST);
        chk("status_rst2", status_rd_data, 8'h00);
        @(posedge clock);
        #1;
        chk("status_after", status_rd_data, 8'h3C);
        test_done;
    end
endmodule
